/* ghb_map.vh */
`ifndef GHB_MAP_VH
`define GHB_MAP_VH
`define GHB_BUS_GENERIC2      3'h7
`define GHB_BS_GENERIC2       1'h1
`define GHB_ENDIAN_LITTLE     1'h0
`define GHB_ENDIAN_BIG        1'h1
`define GHB_ST_IDLE           2'h0
`define GHB_ST_ARB            2'h1
`define GHB_ST_DONE           2'h2
`define GHB_RST_DATA          16'h0000
`endif

/* ghb_host_port.v */
`timescale 1ns/1ps
`include "ghb_map.vh"
module ghb_host_port #(
    parameter AW = 17,
    parameter DW = 16
) (
    input  wire          i_core_clk,
    input  wire          i_rst,
    input  wire [2:0]    i_bus_select_strap,
    input  wire          i_bus_status_strap_n,
    input  wire          i_endian_strap,
    input  wire          i_rd_wr_sel,
    input  wire          i_lcd_block_select_n,
    input  wire          i_read_enable_n,
    input  wire          i_write_enable_n,
    input  wire          i_upper_byte_enable_n,
    input  wire [AW-1:0] i_address_inputs,
    input  wire [DW-1:0] i_data_lines,
    input  wire          i_arb_grant,
    input  wire [DW-1:0] i_mem_rdata,
    output reg  [DW-1:0] o_data_lines,
    output reg           o_data_lines_oe,
    output reg           o_host_ready_line,
    output reg           o_mem_req,
    output reg           o_mem_we,
    output reg  [1:0]    o_mem_be,
    output reg  [AW-1:0] o_mem_addr,
    output reg  [DW-1:0] o_mem_wdata,
    output reg           o_big_endian,
    output reg           o_generic2_mode
);
    // All host pins except i_rd_wr_sel come from the host clock domain, but still pass two stages
    reg  [1:0]    sel_sync;
    reg  [1:0]    rd_sync;
    reg  [1:0]    wr_sync;
    reg  [1:0]    ube_sync;
    reg           rst_d;
    reg  [AW-1:0] addr_s1;
    reg  [AW-1:0] addr_s2;
    reg  [DW-1:0] data_s1;
    reg  [DW-1:0] data_s2;
    reg  [4:0]    strap_s1;
    reg  [4:0]    strap_s2;
    reg  [1:0]    state;
    reg  [1:0]    next_state;
    wire          sel;
    wire          rd;
    wire          wr;
    wire          go;

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            sel_sync <= 2'h0;
            rd_sync  <= 2'h0;
            wr_sync  <= 2'h0;
            ube_sync <= 2'h0;
        end else begin
            sel_sync <= {sel_sync[0], ~i_lcd_block_select_n};
            rd_sync  <= {rd_sync[0], ~i_read_enable_n};
            wr_sync  <= {wr_sync[0], ~i_write_enable_n};
            ube_sync <= {ube_sync[0], ~i_upper_byte_enable_n};
        end
    end

    // Buses take the same two stages so they line up with the strobes
    always @(posedge i_core_clk) begin
        addr_s1  <= i_address_inputs;
        addr_s2  <= addr_s1;
        data_s1  <= i_data_lines;
        data_s2  <= data_s1;
        strap_s1 <= {i_bus_select_strap, i_bus_status_strap_n, i_endian_strap};
        strap_s2 <= strap_s1;
    end

    // i_rd_wr_sel is deliberately unused in this mode
    assign sel = sel_sync[1];
    assign rd  = sel && rd_sync[1];
    assign wr  = sel && wr_sync[1];
    assign go  = o_generic2_mode && (rd || wr);

    // Straps caught in the first clock after reset drops
    always @(posedge i_core_clk) begin
        rst_d <= i_rst;
        if (i_rst) begin
            o_big_endian    <= `GHB_ENDIAN_LITTLE;
            o_generic2_mode <= 1'b0;
        end else if (rst_d) begin
            o_big_endian    <= (strap_s2[0] == `GHB_ENDIAN_BIG);
            o_generic2_mode <= (strap_s2[4:2] == `GHB_BUS_GENERIC2) &&
                               (strap_s2[1] == `GHB_BS_GENERIC2);
        end
    end

    always @* begin
        next_state = state;
        case (state)
            `GHB_ST_IDLE: begin
                if (go) begin
                    next_state = `GHB_ST_ARB;
                end
            end
            `GHB_ST_ARB: begin
                if (!(rd || wr)) begin
                    next_state = `GHB_ST_IDLE;
                end else if (i_arb_grant) begin
                    next_state = `GHB_ST_DONE;
                end
            end
            `GHB_ST_DONE: begin
                // Hold off a new cycle until the strobes drop
                if (!(rd || wr)) begin
                    next_state = `GHB_ST_IDLE;
                end
            end
            default: begin
                next_state = `GHB_ST_IDLE;
            end
        endcase
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            state             <= `GHB_ST_IDLE;
            o_host_ready_line <= 1'b1;
            o_mem_req         <= 1'b0;
            o_mem_we          <= 1'b0;
            o_mem_be          <= 2'h0;
            o_mem_addr        <= {AW{1'b0}};
            o_mem_wdata       <= `GHB_RST_DATA;
            o_data_lines      <= `GHB_RST_DATA;
            o_data_lines_oe   <= 1'b0;
        end else begin
            state <= next_state;
            // Ready low from cycle start until the access is granted
            o_host_ready_line <= !(next_state == `GHB_ST_ARB);
            o_mem_req <= (next_state == `GHB_ST_ARB);
            if (state == `GHB_ST_IDLE && go) begin
                o_mem_we   <= wr;
                o_mem_addr <= addr_s2;
                // Word when upper enable low; else byte picked by address bit 0
                o_mem_be   <= ube_sync[1] ? 2'h3 :
                              (addr_s2[0] ? 2'h2 : 2'h1);
            end
            if (wr) begin
                o_mem_wdata <= data_s2;
            end
            if (state == `GHB_ST_ARB && i_arb_grant && rd) begin
                o_data_lines <= i_mem_rdata;
            end
            // Drive only after data is valid and while select and read hold
            o_data_lines_oe <= rd && (state == `GHB_ST_DONE ||
                               (state == `GHB_ST_ARB && i_arb_grant));
        end
    end
endmodule

/* ghb_chk_chk.sv */
`timescale 1ns/1ps
module ghb_chk (
    input wire i_core_clk, i_rst, i_lcd_block_select_n, i_read_enable_n, i_arb_grant,
    input wire o_data_lines_oe, o_host_ready_line, o_mem_req, o_generic2_mode
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    property p_oe; $rose(o_data_lines_oe) |-> !i_read_enable_n; endproperty
    a_oe: assert property (p_oe) else $error("oe");
    property p_rq; o_mem_req |-> !o_host_ready_line; endproperty
    a_rq: assert property (p_rq) else $error("rq");
    property p_gr; o_mem_req && i_arb_grant |=> o_host_ready_line && !o_mem_req; endproperty
    a_gr: assert property (p_gr) else $error("gr");
    property p_md; !o_generic2_mode |-> o_host_ready_line; endproperty
    a_md: assert property (p_md) else $error("md");
    property p_up; $rose(o_host_ready_line) |-> $past(i_arb_grant); endproperty
    a_up: assert property (p_up) else $error("up");
    property p_dn; $fell(o_host_ready_line) |-> !i_lcd_block_select_n; endproperty
    a_dn: assert property (p_dn) else $error("dn");
    property p_rd; $rose(o_data_lines_oe) |-> $rose(o_host_ready_line); endproperty
    a_rd: assert property (p_rd) else $error("rd");
    property p_dr; o_data_lines_oe |-> o_host_ready_line; endproperty
    a_dr: assert property (p_dr) else $error("dr");
    c_rd: cover property ($rose(o_data_lines_oe));
    c_wt: cover property (o_mem_req && !i_arb_grant);
    c_g2: cover property ($rose(o_generic2_mode));
endmodule
bind ghb_host_port ghb_chk u_chk (.*);

/* ghb_arb.sv */
`timescale 1ns/1ps
module ghb_arb (
    input  wire        i_clk,
    input  wire [16:0] i_addr,
    output reg         o_grant,
    output reg  [15:0] o_rdata
);
    // Random grant mimics refresh contention
    always @(posedge i_clk) o_grant <= $urandom % 3 == 0;
    // Read data follows the latched address at once, valid with any grant
    always @* o_rdata = ~i_addr[15:0];
endmodule

/* tb_generic_host_bus_slave.sv */
`timescale 1ns/1ps
module tb_generic_host_bus_slave;
    reg c = 0, r = 1, s_n = 1, rd_n = 1, wr_n = 1, u_n = 1, e;
    reg [16:0] a = 0;
    reg [15:0] d = 0;
    wire [15:0] q, wd, md;
    wire [16:0] ma;
    wire [1:0] be;
    wire oe, rdy, g2, bg, gr, mw;
    int bad_count = 0, checked = 0;
    initial forever #25 c = ~c;
    ghb_host_port dut_u (.i_core_clk(c), .i_rst(r), .i_bus_select_strap(3'h7),
        .i_bus_status_strap_n(1'h1), .i_endian_strap(e), .i_rd_wr_sel(1'h1),
        .i_lcd_block_select_n(s_n), .i_read_enable_n(rd_n), .i_write_enable_n(wr_n),
        .i_upper_byte_enable_n(u_n), .i_address_inputs(a), .i_data_lines(d),
        .i_arb_grant(gr), .i_mem_rdata(md), .o_data_lines(q), .o_data_lines_oe(oe),
        .o_host_ready_line(rdy), .o_mem_req(), .o_mem_we(mw), .o_mem_be(be), .o_mem_addr(ma),
        .o_mem_wdata(wd), .o_big_endian(bg), .o_generic2_mode(g2));
    ghb_arb arb_u (.i_clk(c), .i_addr(ma), .o_grant(gr), .o_rdata(md));
    task chk(input string n, input [15:0] v, x);
        checked++;
        bad_count += v !== x;
        if (v !== x) $display("wrong value %s exp %h got %h", n, x, v);
    endtask
    task xf(input w, input [16:0] ad);
        @(posedge c);
        {a, d, u_n, s_n, rd_n, wr_n} <= {ad, 16'($urandom), ad[1], 1'h0, w, !w};
        repeat (4) @(posedge c);
        for (int t = 0; !rdy && t < 99; t++) @(posedge c);
        chk("ready", rdy, 1);
        chk("data", w ? wd : q, w ? d : ~ad[15:0]);
        chk("oe", oe, !w);
        chk("we", mw, w);
        chk("lanes", be, ad[1] ? (ad[0] ? 2 : 1) : 3);
        {s_n, rd_n, wr_n} <= 3'h7;
        repeat (6) @(posedge c);
    endtask
    task end_of_test;
        $display("checks %0d bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h214797B9));
        e <= 1'($urandom);
        repeat (16) @(posedge c);
        r <= 0;
        repeat (3) @(posedge c);
        chk("mode", g2, 1);
        chk("endian", bg, e);
        xf(0, 17'h1FFFF);
        repeat (20) xf(1'($urandom), 17'($urandom));
        end_of_test;
    end
    initial begin
        #2000000 bad_count++;
        end_of_test;
    end
endmodule
